// ---- design/bit_skip_call_pkg.sv ----
// Package: shared types and constants for the bit/skip/call execution block
package bit_skip_call_pkg;
  localparam int DATA_W = 8;
  localparam int PC_W = 9;
  localparam int FADDR_W = 6;
  localparam logic [7:0] WORK_RST = 8'h00;
  localparam logic [8:0] PC_RST = 9'h000;
  localparam logic [8:0] PC_STEP = 9'h001;
  localparam int CALL_CYCLES = 2;
  localparam int SKIP_CYCLES = 2;

  // Instruction selector from the decoder stage
  typedef enum logic [2:0] {
    OP_NONE,
    OP_AND_IMM,
    OP_SET_BIT,
    OP_SKIP_CLR,
    OP_SKIP_SET,
    OP_CALL_IMM,
    OP_CALL_COMP
  } op_e;

  typedef struct packed {
    logic valid;
    op_e op;
    logic [7:0] imm;
    logic [5:0] faddr;
    logic [2:0] bitsel;
  } instr_s;

  typedef struct packed {
    logic wr;
    logic [5:0] addr;
    logic [7:0] data;
  } file_wr_s;

  typedef struct packed {
    logic push;
    logic [8:0] data;
  } stack_push_s;
endpackage : bit_skip_call_pkg

// ---- design/bit_skip_flag_unit.sv ----
// Combinational helper: AND result, zero flag, bit set and bit test
`timescale 1ns/1ps
module bit_skip_flag_unit
  import bit_skip_call_pkg::*;
(
  input wire logic [7:0] working_i,
  input wire logic [7:0] imm_i,
  input wire logic [7:0] fdata_i,
  input wire logic [2:0] bitsel_i,
  output logic [7:0] and_o,
  output logic zero_o,
  output logic [7:0] set_o,
  output logic bit_o
);
  function automatic logic [7:0] bit_mask(input logic [2:0] sel);
    bit_mask = 8'h01 << sel;
  endfunction : bit_mask

  always_comb
  begin
    and_o = working_i & imm_i;
    zero_o = (and_o == 8'h00);
    set_o = fdata_i | bit_mask(bitsel_i);
    bit_o = |(fdata_i & bit_mask(bitsel_i));
  end
endmodule : bit_skip_flag_unit

// ---- design/mcu_bit_skip_call_exec.sv ----
// Execution block for AND-immediate, bit set, bit-test skips and subroutine calls
`timescale 1ns/1ps
// Overview of operation
// - AND-immediate ANDs working register with 8-bit immediate into working, one cycle.
// - Set-bit forces chosen bit of file register 0..63 to one, flags untouched.
// - Skip-if-clear skips next instruction when tested bit reads zero.
// - Skip-if-set skips next instruction when tested bit reads one.
// - Taken skip flushes fetched instruction as a no-op; two cycles, else one.
// - Both calls push program counter plus one onto stack first.
// - Immediate call loads its 8-bit target into PC bits 7..0.
// - Immediate call copies upper page latch bit 0 into PC bit 8.
// - Computed call copies table high pointer bit 0 into PC bit 8.
// - Computed call loads working register into PC bits 7..0, no operand.
module mcu_bit_skip_call_exec
  import bit_skip_call_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire bit_skip_call_pkg::instr_s instr_i,
  input wire logic [7:0] fdata_i,
  input wire logic [7:0] upper_page_latch_i,
  input wire logic [7:0] table_high_pointer_i,
  input wire logic work_load_i,
  input wire logic [7:0] work_data_i,
  output logic [7:0] working_register_o,
  output logic zero_flag_o,
  output logic zero_wr_o,
  output bit_skip_call_pkg::file_wr_s file_wr_o,
  output bit_skip_call_pkg::stack_push_s stack_push_o,
  output logic [8:0] pc_o,
  output logic flush_o,
  output logic busy_o
);
  import bit_skip_call_pkg::*;

  typedef enum logic [1:0] {
    ST_RUN,
    ST_FLUSH
  } state_e;

  typedef struct packed {
    state_e state;
    logic [7:0] working;
    logic zero;
    logic zero_wr;
    file_wr_s fwr;
    stack_push_s push;
    logic [8:0] pc;
    logic flush;
    logic busy;
  } state_s;

  state_s s_q;
  state_s s_d;
  logic [7:0] and_res;
  logic and_zero;
  logic [7:0] set_res;
  logic tested_bit;
  logic exec;

  // One step rule keeps fetch order and return address in agreement
  function automatic logic [8:0] pc_inc(input logic [8:0] pc);
    pc_inc = pc + PC_STEP;
  endfunction : pc_inc

  ////////////////////////////////////////////////////////////////////////////
  bit_skip_flag_unit bit_skip_flag_unit_inst (
    .working_i(s_q.working),
    .imm_i(instr_i.imm),
    .fdata_i(fdata_i),
    .bitsel_i(instr_i.bitsel),
    .and_o(and_res),
    .zero_o(and_zero),
    .set_o(set_res),
    .bit_o(tested_bit)
  );

  // The slot after a flush holds the discarded fetch, so nothing executes
  assign exec = instr_i.valid && (s_q.state == ST_RUN);

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    s_d = s_q;
    s_d.zero_wr = 1'b0;
    s_d.fwr.wr = 1'b0;
    s_d.push.push = 1'b0;
    s_d.flush = 1'b0;
    // Other units write the working register; an AND taken in the same cycle wins
    if (work_load_i)
    begin
      s_d.working = work_data_i;
    end
    case (s_q.state)
      ST_RUN:
      begin
        if (exec)
        begin
          s_d.pc = pc_inc(s_q.pc);
          case (instr_i.op)
            OP_AND_IMM:
            begin
              s_d.working = and_res;
              s_d.zero = and_zero;
              s_d.zero_wr = 1'b1;
            end
            OP_SET_BIT:
            begin
              s_d.fwr.wr = 1'b1;
              s_d.fwr.addr = instr_i.faddr;
              s_d.fwr.data = set_res;
            end
            OP_SKIP_CLR:
            begin
              if (!tested_bit)
              begin
                s_d.flush = 1'b1;
                s_d.state = ST_FLUSH;
              end
            end
            OP_SKIP_SET:
            begin
              if (tested_bit)
              begin
                s_d.flush = 1'b1;
                s_d.state = ST_FLUSH;
              end
            end
            OP_CALL_IMM:
            begin
              s_d.push.push = 1'b1;
              s_d.push.data = pc_inc(s_q.pc);
              s_d.pc = {upper_page_latch_i[0], instr_i.imm};
              s_d.flush = 1'b1;
              s_d.state = ST_FLUSH;
            end
            OP_CALL_COMP:
            begin
              s_d.push.push = 1'b1;
              s_d.push.data = pc_inc(s_q.pc);
              s_d.pc = {table_high_pointer_i[0], s_q.working};
              s_d.flush = 1'b1;
              s_d.state = ST_FLUSH;
            end
            default:
            begin
            end
          endcase
        end
      end
      ST_FLUSH:
      begin
        // Skips step past the discarded word; calls already hold target
        if (instr_i.valid && !s_q.push.push)
        begin
          s_d.pc = pc_inc(s_q.pc);
        end
        s_d.state = ST_RUN;
      end
      default:
      begin
        s_d.state = ST_RUN;
      end
    endcase
    s_d.busy = (s_d.state == ST_FLUSH);
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      s_q <= '0;
      s_q.state <= ST_RUN;
      s_q.working <= WORK_RST;
      s_q.pc <= PC_RST;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign working_register_o = s_q.working;
  assign zero_flag_o = s_q.zero;
  assign zero_wr_o = s_q.zero_wr;
  assign file_wr_o = s_q.fwr;
  assign stack_push_o = s_q.push;
  assign pc_o = s_q.pc;
  assign flush_o = s_q.flush;
  assign busy_o = s_q.busy;

  ////////////////////////////////////////////////////////////////////////////
  chk_and_result: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (exec && instr_i.op == OP_AND_IMM) |=> working_register_o == ($past(s_q.working) & $past(instr_i.imm)))
    else $error("AND result wrong");
  chk_zero_flag: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (exec && instr_i.op == OP_AND_IMM) |=> zero_wr_o && (zero_flag_o == (working_register_o == 8'h00)))
    else $error("zero flag wrong");
  chk_set_bit: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (exec && instr_i.op == OP_SET_BIT) |=> file_wr_o.wr
      && file_wr_o.data == ($past(fdata_i) | (8'h01 << $past(instr_i.bitsel)))
      && file_wr_o.addr == $past(instr_i.faddr) && !zero_wr_o)
    else $error("set bit wrong");
  chk_skip_clear: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (exec && instr_i.op == OP_SKIP_CLR && !fdata_i[instr_i.bitsel]) |=> flush_o ##1 !busy_o)
    else $error("skip on clear missed");
  chk_skip_set: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (exec && instr_i.op == OP_SKIP_SET && fdata_i[instr_i.bitsel]) |=> flush_o ##1 !busy_o)
    else $error("skip on set missed");
  chk_noskip_one: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (exec && instr_i.op == OP_SKIP_SET && !fdata_i[instr_i.bitsel]) |=> !busy_o && !flush_o)
    else $error("skip taken wrongly");
  chk_call_push: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (exec && (instr_i.op == OP_CALL_IMM || instr_i.op == OP_CALL_COMP))
      |=> stack_push_o.push && stack_push_o.data == $past(s_q.pc) + 9'h001)
    else $error("return address wrong");
  chk_call_imm_pc: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (exec && instr_i.op == OP_CALL_IMM) |=> pc_o == {$past(upper_page_latch_i[0]), $past(instr_i.imm)})
    else $error("immediate call target wrong");
  chk_call_comp_pc: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (exec && instr_i.op == OP_CALL_COMP) |=> pc_o == {$past(table_high_pointer_i[0]), $past(s_q.working)})
    else $error("computed call target wrong");
  chk_call_two: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (exec && instr_i.op == OP_CALL_COMP) |=> busy_o ##1 (!busy_o && $stable(pc_o)))
    else $error("call not two cycles");

  // AND-immediate
  chk_and_one_cycle: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (exec && instr_i.op == OP_AND_IMM)
      |=> !busy_o && !flush_o && pc_o == $past(s_q.pc) + 9'h001)
    else $error("AND not single cycle");
  chk_zero_value: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (exec && instr_i.op == OP_AND_IMM)
      |=> zero_flag_o == (($past(s_q.working) & $past(instr_i.imm)) == 8'h00))
    else $error("zero flag value wrong");
  chk_zero_only: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (exec && instr_i.op != OP_AND_IMM)
      |=> !zero_wr_o && $stable(zero_flag_o))
    else $error("zero flag touched by other op");

  // Set-bit
  chk_set_bit_flags: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (exec && instr_i.op == OP_SET_BIT && !work_load_i)
      |=> $stable(zero_flag_o) && $stable(working_register_o) && !flush_o && !busy_o)
    else $error("set bit disturbed flags");
  chk_set_bit_only: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (exec && instr_i.op != OP_SET_BIT)
      |=> !file_wr_o.wr)
    else $error("file write by other op");

  // Bit-test skips
  chk_skip_clr_slot: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (exec && instr_i.op == OP_SKIP_CLR && !fdata_i[instr_i.bitsel])
      |=> busy_o && pc_o == $past(s_q.pc) + 9'h001)
    else $error("skip on clear slot wrong");
  chk_skip_set_slot: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (exec && instr_i.op == OP_SKIP_SET && fdata_i[instr_i.bitsel])
      |=> busy_o && pc_o == $past(s_q.pc) + 9'h001)
    else $error("skip on set slot wrong");
  chk_noskip_clear: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (exec && instr_i.op == OP_SKIP_CLR && fdata_i[instr_i.bitsel])
      |=> !busy_o && !flush_o && pc_o == $past(s_q.pc) + 9'h001)
    else $error("skip on clear taken wrongly");
  chk_noskip_set_pc: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (exec && instr_i.op == OP_SKIP_SET && !fdata_i[instr_i.bitsel])
      |=> pc_o == $past(s_q.pc) + 9'h001)
    else $error("untaken skip pc wrong");
  chk_skip_side: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (exec && (instr_i.op == OP_SKIP_CLR || instr_i.op == OP_SKIP_SET))
      |=> !file_wr_o.wr && !stack_push_o.push && !zero_wr_o)
    else $error("skip had side effect");

  // Calls
  chk_call_flush: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (exec && (instr_i.op == OP_CALL_IMM || instr_i.op == OP_CALL_COMP))
      |=> flush_o && busy_o)
    else $error("call did not flush");
  chk_call_imm_two: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (exec && instr_i.op == OP_CALL_IMM)
      |=> busy_o ##1 (!busy_o && $stable(pc_o)))
    else $error("immediate call not two cycles");
  chk_call_side: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (exec && (instr_i.op == OP_CALL_IMM || instr_i.op == OP_CALL_COMP))
      |=> !file_wr_o.wr && !zero_wr_o)
    else $error("call had side effect");
  chk_push_pulse: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    stack_push_o.push
      |=> !stack_push_o.push)
    else $error("push longer than one cycle");
  chk_push_only: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (exec && instr_i.op != OP_CALL_IMM && instr_i.op != OP_CALL_COMP)
      |=> !stack_push_o.push)
    else $error("push by other op");

  // Discarded slot: a refused word must leave no trace
  chk_slot_noop: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    busy_o
      |=> !busy_o && !flush_o && !file_wr_o.wr && !stack_push_o.push && !zero_wr_o)
    else $error("discarded slot executed");
  chk_slot_skip_pc: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (busy_o && !stack_push_o.push && instr_i.valid)
      |=> pc_o == $past(pc_o) + 9'h001)
    else $error("skip slot pc wrong");
  chk_slot_idle_pc: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (busy_o && !instr_i.valid)
      |=> $stable(pc_o))
    else $error("idle slot moved pc");
  chk_flush_pulse: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    flush_o
      |=> !flush_o)
    else $error("flush longer than one cycle");
endmodule : mcu_bit_skip_call_exec

// ---- tb/tb_mcu_bit_skip_call_exec.sv ----
// Self-checking bench for the bit/skip/call execution block
`timescale 1ns/1ps
module tb_mcu_bit_skip_call_exec;
  import bit_skip_call_pkg::*;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  instr_s instr_i = '0;
  logic [7:0] fdata_i = 8'h00;
  logic [7:0] upper_page_latch_i = 8'h00;
  logic [7:0] table_high_pointer_i = 8'h00;
  logic work_load_i = 1'b0;
  logic [7:0] work_data_i = 8'h00;
  logic [7:0] working_register_o;
  logic zero_flag_o;
  logic zero_wr_o;
  file_wr_s file_wr_o;
  stack_push_s stack_push_o;
  logic [8:0] pc_o;
  logic flush_o;
  logic busy_o;
  int miscompares = 0;
  int cmp_count = 0;
  logic [8:0] pc_m;
  logic [7:0] w_m;
  logic [17:0] zq[$];
  logic [17:0] fq[$];
  logic [17:0] sq[$];
  logic [17:0] pq[$];
  always #50 mclk_i = ~mclk_i;
  mcu_bit_skip_call_exec mcu_bit_skip_call_exec_inst (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .instr_i(instr_i),
    .fdata_i(fdata_i),
    .upper_page_latch_i(upper_page_latch_i),
    .table_high_pointer_i(table_high_pointer_i),
    .work_load_i(work_load_i),
    .work_data_i(work_data_i),
    .working_register_o(working_register_o),
    .zero_flag_o(zero_flag_o),
    .zero_wr_o(zero_wr_o),
    .file_wr_o(file_wr_o),
    .stack_push_o(stack_push_o),
    .pc_o(pc_o),
    .flush_o(flush_o),
    .busy_o(busy_o)
  );
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [17:0] e, input logic [17:0] g);
    cmp_count++;
    if ((g !== e) || $isunknown(e))
    begin
      miscompares++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : check
  // Empty queue yields unknown, which check always counts as a mismatch
  function automatic logic [17:0] pop(ref logic [17:0] q[$]);
    if (q.size() == 0)
      return 'x;
    return q.pop_front();
  endfunction : pop
  task automatic final_report();
    if (miscompares == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : final_report
  ////////////////////////////////////////////////////////////////////////////////
  task automatic issue(input op_e op, input logic [7:0] imm, input logic [7:0] fd, input logic vld);
    instr_s ins;
    logic [7:0] lat;
    logic [7:0] thp;
    logic skip;
    logic call;
    logic [8:0] nxt;
    instr_s fil;
    logic ld;
    logic [7:0] ldv;
    ins = '{vld, op, imm, 6'($urandom), 3'($urandom)};
    lat = 8'($urandom);
    thp = 8'($urandom);
    ld = 1'($urandom);
    ldv = 8'($urandom);
    @(posedge mclk_i);
    instr_i <= ins;
    fdata_i <= fd;
    upper_page_latch_i <= lat;
    table_high_pointer_i <= thp;
    work_load_i <= ld;
    work_data_i <= ldv;
    skip = vld && ((op == OP_SKIP_CLR && !fd[ins.bitsel]) || (op == OP_SKIP_SET && fd[ins.bitsel]));
    call = vld && (op == OP_CALL_IMM || op == OP_CALL_COMP);
    if (vld && op == OP_AND_IMM)
      zq.push_back({9'h000, ~|(w_m & imm), w_m & imm});
    if (vld && op == OP_AND_IMM)
      w_m = w_m & imm;
    if (vld && op == OP_SET_BIT)
      fq.push_back({4'h0, ins.faddr, fd | (8'h01 << ins.bitsel)});
    nxt = pc_m + (vld ? PC_STEP : 9'h000);
    if (call)
      nxt = op == OP_CALL_IMM ? {lat[0], imm} : {thp[0], w_m};
    if (call)
      sq.push_back({pc_m + PC_STEP, nxt});
    pc_m = nxt;
    if (ld && !(vld && op == OP_AND_IMM))
      w_m = ldv;
    if (skip || call)
    begin
      pq.push_back({8'h00, 1'b1, nxt});
      // Refused slot: any op may sit there; only a skip steps past a live one
      fil = '{($urandom % 4) != 0, op_e'($urandom % 7), 8'($urandom), 6'($urandom), 3'($urandom)};
      @(posedge mclk_i);
      instr_i <= fil;
      if (skip && fil.valid)
        pc_m = pc_m + PC_STEP;
    end
  endtask : issue
  ////////////////////////////////////////////////////////////////////////////////
  always @(negedge mclk_i)
  begin
    if (rst_n_i === 1'b1)
    begin
      if (zero_wr_o !== 1'b0)
        check(pop(zq), {9'h000, zero_flag_o, working_register_o});
      if (file_wr_o.wr !== 1'b0)
        check(pop(fq), {4'h0, file_wr_o.addr, file_wr_o.data});
      if (stack_push_o.push !== 1'b0)
        check(pop(sq), {stack_push_o.data, pc_o});
      if (flush_o !== 1'b0)
        check(pop(pq), {8'h00, busy_o, pc_o});
    end
  end
  initial
  begin
    void'($urandom(32'hb5f2));
    pc_m = PC_RST;
    // Preloaded at release so the first AND gives a nonzero result
    w_m = 8'h5A;
    repeat (4) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    work_load_i <= 1'b1;
    work_data_i <= 8'h5A;
    check({1'b0, WORK_RST, PC_RST}, {1'b0, working_register_o, pc_o});
    issue(OP_AND_IMM, 8'hAF, 8'h5A, 1'b1);
    issue(OP_SET_BIT, 8'h00, 8'h5A, 1'b1);
    issue(OP_CALL_COMP, 8'h00, 8'h00, 1'b1);
    repeat (400) issue(op_e'($urandom % 7), 8'($urandom), 8'($urandom), ($urandom % 8) != 0);
    repeat (3) @(posedge mclk_i);
    check(18'h00000, 18'(zq.size() + fq.size() + sq.size() + pq.size()));
    final_report();
  end
endmodule : tb_mcu_bit_skip_call_exec
